/* File: hdl/lsu_pkg.sv */
// shared constants and types for the load/store address and align unit
package lsu_pkg;
    localparam int DATA_W = 32;                  // data path width
    localparam int ADDR_W = 32;                  // address width
    localparam int OFFS_W = 16;                  // offset field width
    localparam int OFFS_SIGN_BIT = 15;           // sign bit of the offset
    localparam int REG_W = 5;                    // register index width
    localparam int LD_DELAY = 1;                 // load delay in instructions
    localparam logic [1:0] WORD_MASK = 2'h3;     // low bits for word alignment
    localparam logic [1:0] HALF_MASK = 2'h1;     // low bit for halfword alignment
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0; // reset value of data
    localparam logic [3:0] BE_NONE = 4'h0;       // no byte lanes
    localparam logic [3:0] BE_ALL = 4'hf;        // all byte lanes

    // operation codes presented by the pipeline
    typedef enum logic [3:0] {
        OP_NONE,
        OP_LOAD_SIGNED_BYTE,
        OP_LOAD_UNSIGNED_BYTE,
        OP_LOAD_SIGNED_HALF,
        OP_LOAD_UNSIGNED_HALF,
        OP_LOAD_WORD,
        OP_LOAD_LEFT,
        OP_LOAD_RIGHT,
        OP_STORE_BYTE,
        OP_STORE_HALF,
        OP_STORE_WORD,
        OP_STORE_LEFT,
        OP_STORE_RIGHT
    } lsu_op_e;
endpackage : lsu_pkg

/* File: hdl/lsu_merge.sv */
// load data extraction: extension and partial-word merge
`timescale 1ns/1ns
`default_nettype none
module lsu_merge (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire lsu_pkg::lsu_op_e i_op,
    input wire logic [1:0] i_lane,
    input wire logic [lsu_pkg::DATA_W-1:0] i_mem,
    input wire logic [lsu_pkg::DATA_W-1:0] i_old,
    output logic [lsu_pkg::DATA_W-1:0] o_value
);
    import lsu_pkg::*;

    // memory word shifted so the addressed byte or half sits at bit 0
    wire [DATA_W-1:0] shifted = i_mem >> {i_lane, 3'h0};
    // bytes counted from the addressed byte upward, for the left form
    wire [4:0] left_sh = 5'({2'h3 - i_lane, 3'h0});
    wire [4:0] right_sh = 5'({i_lane, 3'h0});
    // left load: addressed byte and those below it fill the upper end
    wire [DATA_W-1:0] left_mask = {DATA_W{1'b1}} << left_sh;
    wire [DATA_W-1:0] left_val = i_mem << left_sh;
    // right load: addressed byte and those above fill the lower end
    wire [DATA_W-1:0] right_mask = {DATA_W{1'b1}} >> right_sh;
    wire [DATA_W-1:0] right_val = i_mem >> right_sh;
    logic [DATA_W-1:0] next_value;

    // select the extended or merged result
    always_comb begin
        unique case (i_op)
            // signed forms copy the top bit of the fetched field upward
            OP_LOAD_SIGNED_BYTE: begin
                next_value = {{24{shifted[7]}}, shifted[7:0]};
            end
            OP_LOAD_UNSIGNED_BYTE: next_value = {24'h0, shifted[7:0]};
            OP_LOAD_SIGNED_HALF: begin
                next_value = {{16{shifted[15]}}, shifted[15:0]};
            end
            OP_LOAD_UNSIGNED_HALF: next_value = {16'h0, shifted[15:0]};
            OP_LOAD_LEFT: begin
                // untouched bytes keep the register's old content
                next_value = (left_val & left_mask) |
                    (i_old & ~left_mask);
            end
            OP_LOAD_RIGHT: begin
                next_value = (right_val & right_mask) |
                    (i_old & ~right_mask);
            end
            default: next_value = i_mem; // whole word
        endcase
    end

    // registered so the result leaves on a flip-flop
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_value <= ZERO_WORD;
        end else begin
            o_value <= next_value;
        end
    end
endmodule : lsu_merge
`default_nettype wire

/* File: hdl/lsu_align.sv */
// load/store unit: address forming, alignment check, load data, hazards
//
// Overview of operation
// - signed loads sign-extend, unsigned loads zero-extend
// - misaligned word or halfword raises address exception
// - left/right partial forms never raise alignment exception
// - load result unusable by the very next instruction
// - left/right pair to same register needs no gap
// - address is base register plus signed offset
// - offset bit 15 set means subtract
`timescale 1ns/1ns
`default_nettype none
module lsu_align (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic i_valid,
    input wire lsu_pkg::lsu_op_e i_op,
    input wire logic [lsu_pkg::ADDR_W-1:0] i_base,
    input wire logic [lsu_pkg::OFFS_W-1:0] i_offset,
    input wire logic [lsu_pkg::REG_W-1:0] i_dest,
    input wire logic [lsu_pkg::REG_W-1:0] i_src_a,
    input wire logic [lsu_pkg::REG_W-1:0] i_src_b,
    input wire logic [lsu_pkg::DATA_W-1:0] i_store_data,
    input wire logic [lsu_pkg::DATA_W-1:0] i_dest_old,
    input wire logic [lsu_pkg::DATA_W-1:0] i_mem_rdata,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [lsu_pkg::ADDR_W-1:0] o_mem_addr,
    output logic [3:0] o_mem_be,
    output logic [lsu_pkg::DATA_W-1:0] o_mem_wdata,
    output logic o_addr_exc,
    output logic [lsu_pkg::ADDR_W-1:0] o_bad_addr,
    output logic o_load_use,
    output logic o_wb_valid,
    output logic [lsu_pkg::REG_W-1:0] o_wb_reg,
    output logic [lsu_pkg::DATA_W-1:0] o_wb_data
);
    import lsu_pkg::*;

    // pipeline timing, in edges from the one that takes an instruction:
    // at edge 0 the request, exception and hazard flags are registered;
    // at edge 1 the memory word is sampled, extended or merged, and
    // handed back with its destination register
    // an instruction may be taken on every edge and nothing here ever
    // stalls: holding off a consumer when o_load_use rises is the
    // pipeline's job
    // a faulting access makes neither a memory request nor a write-back

    // classify an operation
    // loads are the only operations that return a word to a register
    function automatic logic is_load(input lsu_op_e op);
        is_load = op inside {OP_LOAD_SIGNED_BYTE, OP_LOAD_UNSIGNED_BYTE,
            OP_LOAD_SIGNED_HALF, OP_LOAD_UNSIGNED_HALF, OP_LOAD_WORD,
            OP_LOAD_LEFT, OP_LOAD_RIGHT};
    endfunction : is_load

    // partial forms carry their own byte extent and are never refused
    function automatic logic is_partial(input lsu_op_e op);
        is_partial = op inside {OP_LOAD_LEFT, OP_LOAD_RIGHT,
            OP_STORE_LEFT, OP_STORE_RIGHT};
    endfunction : is_partial

    // effective address: offset sign-extended then added
    wire [ADDR_W-1:0] offs_ext =
        {{(ADDR_W-OFFS_W){i_offset[OFFS_SIGN_BIT]}}, i_offset};
    wire [ADDR_W-1:0] eff_addr = i_base + offs_ext;
    wire [1:0] lane = eff_addr[1:0];

    // width classes drive the alignment test
    wire word_acc = (i_op == OP_LOAD_WORD) || (i_op == OP_STORE_WORD);
    wire half_acc = (i_op == OP_LOAD_SIGNED_HALF) ||
        (i_op == OP_LOAD_UNSIGNED_HALF) || (i_op == OP_STORE_HALF);
    wire byte_acc = (i_op == OP_LOAD_SIGNED_BYTE) ||
        (i_op == OP_LOAD_UNSIGNED_BYTE) || (i_op == OP_STORE_BYTE);
    // partial forms are exempt because they are not word or half classes
    wire misaligned = !is_partial(i_op) &&
        ((word_acc && ((lane & WORD_MASK) != 2'h0)) ||
         (half_acc && ((lane & HALF_MASK) != 2'h0)));
    wire active = i_valid && (i_op != OP_NONE);
    wire fault = active && misaligned;
    wire go = active && !misaligned;
    wire is_store = !is_load(i_op);

    // byte enables: byte/half by lane, left/right by lane extent
    wire [3:0] be_byte = 4'h1 << lane;
    wire [3:0] be_half = 4'h3 << lane;
    wire [3:0] be_left = 4'hf >> (2'h3 - lane);
    wire [3:0] be_right = 4'hf << lane;
    wire [3:0] be_sel =
        byte_acc ? be_byte :
        half_acc ? be_half :
        (i_op == OP_LOAD_LEFT || i_op == OP_STORE_LEFT) ? be_left :
        (i_op == OP_LOAD_RIGHT || i_op == OP_STORE_RIGHT) ? be_right :
        BE_ALL;
    // store data positioned on its lanes
    wire [4:0] lsh = 5'({lane, 3'h0});
    wire [4:0] lft = 5'({2'h3 - lane, 3'h0});
    wire [DATA_W-1:0] wdata_sel =
        (i_op == OP_STORE_LEFT) ? (i_store_data >> lft) :
        (i_op == OP_STORE_WORD) ? i_store_data :
        (i_store_data << lsh);

    // load in flight: previous instruction was a load to this register
    logic pend_load;
    logic pend_partial;
    lsu_op_e pend_op;
    logic [REG_W-1:0] pend_reg;
    logic [1:0] pend_lane;
    logic [DATA_W-1:0] pend_old;

    // complementary partial load to the same register is exempt
    wire pair_ok = pend_partial && i_valid && pend_reg == i_dest &&
        ((pend_op == OP_LOAD_LEFT && i_op == OP_LOAD_RIGHT) ||
         (pend_op == OP_LOAD_RIGHT && i_op == OP_LOAD_LEFT));
    // any other reader of the pending register breaks the delay slot;
    // register zero never carries a value so it never conflicts
    wire reads_pend = i_valid && pend_load && pend_reg != '0 &&
        (i_src_a == pend_reg || i_src_b == pend_reg);
    wire next_load_use = reads_pend && !pair_ok;
    // the second of a pair merges onto the first one's result, which
    // reaches o_wb_data only at the edge that takes the second, so the
    // choice is made one stage later, at the merge itself
    logic pend_pair;
    wire [DATA_W-1:0] merge_old = pend_pair ? o_wb_data : pend_old;

    // memory request stage: one registered request per accepted access;
    // the address always goes out word aligned and the lanes say which
    // bytes of that word take part
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= '0;
            o_mem_be <= BE_NONE;
            o_mem_wdata <= ZERO_WORD;
        end else begin
            o_mem_req <= go;
            o_mem_we <= go && is_store;
            o_mem_addr <= {eff_addr[ADDR_W-1:2], 2'h0};
            // lanes drop to none so a stale pattern never looks live
            o_mem_be <= go ? be_sel : BE_NONE;
            o_mem_wdata <= wdata_sel;
        end
    end

    // exception stage: the flag lasts one cycle, the address it reports
    // is held until the next fault so a slow handler can still read it
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_addr_exc <= 1'b0;
            o_bad_addr <= '0;
        end else begin
            o_addr_exc <= fault;
            o_bad_addr <= fault ? eff_addr : o_bad_addr;
        end
    end

    // hazard stage: flags the consumer sitting in a load's delay slot;
    // the pipeline, not this unit, decides whether to stall or trap
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_load_use <= 1'b0;
        end else begin
            o_load_use <= next_load_use;
        end
    end

    // tracking of the load now waiting on memory data; cleared between
    // loads so a bubble never looks like a pending result
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            pend_load <= 1'b0;
            pend_partial <= 1'b0;
            pend_pair <= 1'b0;
            pend_op <= OP_NONE;
        end else begin
            pend_load <= go && is_load(i_op);
            pend_partial <= go &&
                (i_op == OP_LOAD_LEFT || i_op == OP_LOAD_RIGHT);
            // set only for the second of a complementary pair
            pend_pair <= go && pair_ok;
            pend_op <= go ? i_op : OP_NONE;
        end
    end

    // side data of the pending load; taken every cycle because it is
    // only looked at while pend_op names a load
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            pend_reg <= '0;
            pend_lane <= 2'h0;
            pend_old <= ZERO_WORD;
        end else begin
            pend_reg <= i_dest;
            pend_lane <= lane;
            // register content before the load, for the bytes it spares
            pend_old <= i_dest_old;
        end
    end

    // write-back valid and register are registered on the same edge as the data
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_wb_valid <= 1'b0;
            o_wb_reg <= '0;
        end else begin
            o_wb_valid <= pend_load;
            o_wb_reg <= pend_reg;
        end
    end

    // extension and merge of the returned word
    lsu_merge u_merge (
        .I_SYS_CLK(I_SYS_CLK),
        .I_RST(I_RST),
        .i_op(pend_op),
        .i_lane(pend_lane),
        .i_mem(i_mem_rdata),
        .i_old(merge_old),
        .o_value(o_wb_data)
    );
endmodule : lsu_align
`default_nettype wire

/* File: tb/lsu_align_chk.sv */
// port assertions for the load/store address and align unit
`timescale 1ns/1ns
`default_nettype none
module lsu_align_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic i_valid,
    input wire lsu_pkg::lsu_op_e i_op,
    input wire logic [31:0] i_base,
    input wire logic [15:0] i_offset,
    input wire logic [4:0] i_dest,
    input wire logic [4:0] i_src_a,
    input wire logic [31:0] i_store_data,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire logic [31:0] o_mem_addr,
    input wire logic [3:0] o_mem_be,
    input wire logic [31:0] o_mem_wdata,
    input wire logic o_addr_exc,
    input wire logic [31:0] o_bad_addr,
    input wire logic o_load_use,
    input wire logic o_wb_valid
);
    import lsu_pkg::*;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    // effective address and class of the instruction taken now
    wire [31:0] ea = i_base + {{16{i_offset[15]}}, i_offset};
    wire go = i_valid && i_op != OP_NONE;
    wire wd = i_op == OP_LOAD_WORD || i_op == OP_STORE_WORD;
    wire hf = i_op inside {OP_LOAD_SIGNED_HALF, OP_LOAD_UNSIGNED_HALF,
        OP_STORE_HALF};
    wire bad = go && (wd && ea[1:0] != 2'h0 || hf && ea[0]);
    // store data on its lanes, and the lanes of a partial access
    wire st = go && !bad && i_op inside {[OP_STORE_BYTE:OP_STORE_RIGHT]};
    wire lf = i_op == OP_LOAD_LEFT || i_op == OP_STORE_LEFT;
    wire [31:0] st_pos = i_op == OP_STORE_LEFT ?
        i_store_data >> {~ea[1:0], 3'h0} : i_store_data << {ea[1:0], 3'h0};
    wire [3:0] lr_be = lf ? 4'hf >> ~ea[1:0] : 4'hf << ea[1:0];
    logic ld_q; // last taken was an ordinary load
    logic lft_q; // last taken was a left partial load
    logic [4:0] dst_q; // its target register
    // partial loads kept out of ld_q: a pair must not count as a hazard
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            ld_q <= 1'b0;
            lft_q <= 1'b0;
        end else begin
            ld_q <= go && !bad &&
                i_op inside {[OP_LOAD_SIGNED_BYTE:OP_LOAD_WORD]};
            lft_q <= go && i_op == OP_LOAD_LEFT;
        end
    end
    always_ff @(posedge I_SYS_CLK) dst_q <= i_dest;
    property p_exc; bad |=> o_addr_exc && !o_mem_req; endproperty
    a_exc: assert property (p_exc)
        else $error("misaligned access not refused");
    property p_bad; bad |=> o_bad_addr == $past(ea); endproperty
    a_bad: assert property (p_bad)
        else $error("wrong fault address");
    property p_ok; !bad |=> !o_addr_exc; endproperty
    a_ok: assert property (p_ok)
        else $error("fault without cause");
    property p_addr;
        go && !bad |=> o_mem_req && o_mem_addr == ($past(ea) & 32'hfffffffc);
    endproperty
    a_addr: assert property (p_addr)
        else $error("wrong memory address");
    property p_lr; go && i_op inside {OP_LOAD_LEFT, OP_LOAD_RIGHT,
        OP_STORE_LEFT, OP_STORE_RIGHT} |=> o_mem_req && !o_addr_exc
        && o_mem_be == $past(lr_be); endproperty
    a_lr: assert property (p_lr)
        else $error("partial access refused or on wrong lanes");
    property p_st;
        st |=> o_mem_req && o_mem_we && o_mem_wdata == $past(st_pos);
    endproperty
    a_st: assert property (p_st)
        else $error("store data off its lanes");
    property p_use;
        ld_q && go && i_src_a == dst_q && dst_q != 5'h0 |=> o_load_use;
    endproperty
    a_use: assert property (p_use)
        else $error("load delay hazard missed");
    property p_pair; lft_q && go && i_op == OP_LOAD_RIGHT
        && i_dest == dst_q |=> !o_load_use; endproperty
    a_pair: assert property (p_pair)
        else $error("partial pair flagged");
    property p_wb; o_mem_req && !o_mem_we |-> ##[1:2] o_wb_valid; endproperty
    a_wb: assert property (p_wb)
        else $error("load result missing");
endmodule : lsu_align_chk
`default_nettype wire

/* File: tb/lsu_mem_model.sv */
// data memory partner: answers the requested word in the request cycle
`timescale 1ns/1ns
`default_nettype none
module lsu_mem_model (
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    output logic [31:0] o_rdata
);
    // word is a scramble of its address; idle bus shows the inverse, so a
    // late sample never passes by chance
    wire [31:0] w = i_addr ^ {i_addr[15:0], i_addr[31:16]} ^ 32'h5a3c96e1;
    assign o_rdata = i_req ? w : ~w;
endmodule : lsu_mem_model
`default_nettype wire

/* File: tb/load_store_address_align_tb_top.sv */
// self-checking bench for the load/store address and align unit
`timescale 1ns/1ns
`default_nettype none
module load_store_address_align_tb_top;
    import lsu_pkg::*;
    logic clk = 1'b0, rst = 1'b1, vld = 1'b0;
    lsu_op_e op = OP_NONE;
    logic [31:0] base = 32'h0, sd = 32'h0, old = 32'h0;
    logic [15:0] off = 16'h0;
    logic [4:0] dst = 5'h0, sa = 5'h0;
    wire [31:0] mrd, madr, bad, wbd;
    wire req, exc, wbv;
    wire [4:0] wbr;
    logic [36:0] qw[$], qe[$]; // expected results, oldest first
    int n_errors = 0, n_checks = 0, cyc = 0, seed = 32'h64cd293e;
    lsu_align lsu_align_inst (.I_SYS_CLK(clk), .I_RST(rst), .i_valid(vld),
        .i_op(op), .i_base(base), .i_offset(off), .i_dest(dst),
        .i_src_a(sa), .i_src_b(dst), .i_store_data(sd), .i_dest_old(old),
        .i_mem_rdata(mrd), .o_mem_req(req), .o_mem_we(), .o_mem_addr(madr),
        .o_mem_be(), .o_mem_wdata(), .o_addr_exc(exc), .o_bad_addr(bad),
        .o_load_use(), .o_wb_valid(wbv), .o_wb_reg(wbr), .o_wb_data(wbd));
    lsu_mem_model lsu_mem_model_inst (.i_req(req), .i_addr(madr),
        .o_rdata(mrd));
    always #10 clk = ~clk;
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic cmp(string nm, logic [36:0] e, logic [36:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // memory word at an address, as the partner holds it
    function automatic logic [31:0] mw(logic [31:0] a);
        logic [31:0] w;
        w = a & 32'hfffffffc;
        return w ^ {w[15:0], w[31:16]} ^ 32'h5a3c96e1;
    endfunction : mw
    // left lifts low lanes to the top, right drops high lanes to the bottom
    function automatic logic [31:0] mrg(logic [31:0] o, m, logic [1:0] l,
        logic lf);
        logic [4:0] s;
        s = lf ? {~l, 3'h0} : {l, 3'h0};
        return lf ? (m << s) | (o & ~(32'hffffffff << s))
            : (m >> s) | (o & ~(32'hffffffff >> s));
    endfunction : mrg
    // one instruction per falling edge; k=1 load result, k=2 fault
    task automatic issue(lsu_op_e p, logic [31:0] b, logic [15:0] f,
        logic [4:0] d, s, logic [36:0] e, logic [1:0] k);
        @(negedge clk);
        vld = 1'b1;
        op = p;
        {base, off, dst, sa, old} = {b, f, d, s, b ^ 32'h0ff0};
        sd = $random(seed);
        if (k == 2'h1) qw.push_back(e);
        if (k == 2'h2) qe.push_back(e);
    endtask : issue
    // hang guard, far above the roughly 120 cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            complete_run();
        end
    end
    // each result is paired with the oldest note of its kind
    always @(negedge clk) begin
        if (!rst && wbv === 1'b1) cmp("load result", qw.size() ?
            qw.pop_front() : 'x, {wbr, wbd});
        if (!rst && exc === 1'b1) cmp("fault address", qe.size() ?
            qe.pop_front() : 'x, {5'h0, bad});
    end
    initial begin
        logic [31:0] b, a, m, e1;
        logic [15:0] f;
        logic [4:0] d;
        logic [1:0] k;
        lsu_op_e p;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // every load size at random aligned places, then a misaligned
        // access that also reads the load's register at once
        for (int i = 0; i < 40; i++) begin
            p = lsu_op_e'(1 + i % 5);
            k = p < OP_LOAD_SIGNED_HALF ? 2'h0 : p < OP_LOAD_WORD ? 2'h1 : 2'h3;
            b = $random(seed);
            f = $random(seed);
            d = $random(seed) | 1;
            a = b + {{16{f[15]}}, f};
            b = b - (a & k);
            a = a - (a & k);
            m = mw(a) >> {a[1:0], 3'h0};
            case (p)
                OP_LOAD_SIGNED_BYTE: m = {{24{m[7]}}, m[7:0]};
                OP_LOAD_UNSIGNED_BYTE: m = {24'h0, m[7:0]};
                OP_LOAD_SIGNED_HALF: m = {{16{m[15]}}, m[15:0]};
                OP_LOAD_UNSIGNED_HALF: m = {16'h0, m[15:0]};
                default: ;
            endcase
            issue(p, b, f, d, 5'h0, {d, m}, 2'h1);
            p = i % 2 ? OP_STORE_HALF : OP_LOAD_WORD;
            m = {31'h0, ~a[0]};
            issue(p, b + m, f, 5'h2, d, {5'h0, a + m}, 2'h2);
        end
        // left/right pairs to one register, back to back, both orders;
        // the second merges onto the first, not the stale register
        for (int i = 0; i < 8; i++) begin
            a = $random(seed);
            d = 5'h3 + i;
            p = i % 2 ? OP_LOAD_RIGHT : OP_LOAD_LEFT;
            m = i % 2 ? a : a + 32'h3;
            e1 = mrg(m ^ 32'h0ff0, mw(m), m[1:0], !i[0]);
            issue(p, m, 16'h0, d, 5'h0, {d, e1}, 2'h1);
            p = i % 2 ? OP_LOAD_LEFT : OP_LOAD_RIGHT;
            m = i % 2 ? a + 32'h3 : a;
            issue(p, m, 16'h0, d, 5'h0, {d, mrg(e1, mw(m), m[1:0], i[0])},
                2'h1);
        end
        // aligned stores of every kind put random data on their lanes
        for (int i = 0; i < 10; i++) begin
            p = lsu_op_e'(OP_STORE_BYTE + i % 5);
            k = i % 5 == 1 ? 2'h1 : i % 5 == 2 ? 2'h3 : 2'h0;
            b = $random(seed);
            f = $random(seed);
            a = b + {{16{f[15]}}, f};
            issue(p, b - (a & k), f, 5'h1, 5'h0, 37'h0, 2'h0);
        end
        @(negedge clk);
        vld = 1'b0;
        op = OP_NONE;
        repeat (6) @(negedge clk);
        cmp("notes left", 37'h0, 37'(qw.size() + qe.size()));
        complete_run();
    end
endmodule : load_store_address_align_tb_top
bind lsu_align lsu_align_chk lsu_align_chk_inst (.I_SYS_CLK, .I_RST,
    .i_valid, .i_op, .i_base, .i_offset, .i_dest, .i_src_a, .i_store_data,
    .o_mem_be, .o_mem_wdata, .o_mem_req,
    .o_mem_we, .o_mem_addr, .o_addr_exc, .o_bad_addr, .o_load_use,
    .o_wb_valid);
`default_nettype wire
